// ==== design/tmr_edge_det.sv ====
// Purpose: synchronise, noise-filter and edge-detect one capture input
// Assumes: i_smp strobes the noise sampling clock
// Notes: edge memory stays clear after reset until the first enable
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_det
  import tmr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_pin,
  input wire logic i_smp,
  input wire logic i_en,
  input wire logic [1:0] i_sel,
  output logic o_evt
);
  logic sync1_r, sync2_r, samp_r, filt_r, prev_r, ran_r;
  logic rise, fall;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (i_ce) begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
    end
  end

  // two equal samples needed, so a one-sample glitch is dropped
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      samp_r <= 1'b0;
      filt_r <= 1'b0;
    end else if (i_ce && i_smp) begin
      samp_r <= sync2_r;
      if (samp_r == sync2_r) begin
        filt_r <= sync2_r;
      end
    end
  end

  // prev tracks the level while stopped only once it has ever run
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_r <= 1'b0;
      ran_r <= 1'b0;
    end else if (i_ce) begin
      if (i_en) begin
        ran_r <= 1'b1;
      end
      if (i_en || ran_r) begin
        prev_r <= filt_r; // RL8 RL9
      end
    end
  end

  assign rise = filt_r && !prev_r;
  assign fall = !filt_r && prev_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_evt <= 1'b0;
    end else if (i_ce) begin
      o_evt <= i_en && ((rise && (i_sel == EDGE_RISE || i_sel == EDGE_BOTH)) ||
                        (fall && (i_sel == EDGE_FALL || i_sel == EDGE_BOTH)));
    end
  end

  a_rise_first_run: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && i_en && rise && i_sel == EDGE_RISE) |=> o_evt) // RL8
    else $error("rising edge not reported while enabled");
  a_no_rise_stopped: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && ran_r && !i_en) |=> (prev_r == $past(filt_r))) // RL9
    else $error("edge memory not tracking level while stopped");
endmodule // tmr_edge_det
`default_nettype wire

// ==== design/tmr_pkg.sv ====
// Purpose: shared constants for the timer/event counter block
// Assumes: 32-bit APB, byte addresses, word-aligned registers
// Notes: all offsets and the control, output and status field positions live here, plus the compare reset value
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
  // control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR_MATCH = 1;
  localparam int CTRL_CLR_EDGE = 2;
  // output control register fields
  localparam int OC_TOE = 0;
  localparam int OC_INV1 = 1;
  localparam int OC_FF_RST = 2;
  localparam int OC_FF_SET = 3;
  localparam int OC_INV2 = 4;
  localparam int OC_OSPE = 5;
  localparam int OC_OSPT = 6;
  localparam int OC_FF_STATE = 7;
  // status fields, write one to clear
  localparam int ST_EDGE1 = 0;
  localparam int ST_EDGE2 = 1;
  localparam int ST_MATCH1 = 2;
  localparam int ST_MATCH2 = 3;
  localparam int ST_W = 4;
  // prescaler select codes
  localparam logic [1:0] PS_DIV2 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV16 = 2'h2;
  localparam logic [1:0] PS_EXT = 2'h3;
  localparam logic [3:0] PS_MASK2 = 4'h1;
  localparam logic [3:0] PS_MASK4 = 4'h3;
  localparam logic [3:0] PS_MASK16 = 4'hF;
  // valid edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'hFFFF;
endpackage

// ==== design/tmr_timer.sv ====
// Purpose: 16-bit timer/event counter with output flip-flop and APB registers
// Assumes: i_core_clk 100 MHz, ring oscillator and capture pins asynchronous
// Notes: one wait-free APB access; stopping the counter clears it
// Overview of operation
// RL1: software spaces one-shot triggers two count clocks
// RL2: never set flip-flop before output enable
// RL3: configure output first, then set/reset flip-flop
// RL4: ring oscillator CPU clock divides into count
// RL5: ring oscillator samples external inputs then
// RL6: prescaler written only while counting stopped
// RL7: edge clock excludes edge clear and capture
// RL8: high pin after reset gives rising edge
// RL9: re-enable with high pin gives no edge
// RL10: shared pin is capture input or output
// RL11: one-shot trigger bit self-clears, reads zero
// RL12: flip-flop set and reset bits read zero
// RL13: pulse width change follows a safe sequence
// RL14: output pin follows flip-flop only when enabled
`timescale 1ns/1ps
`default_nettype none
module tmr_timer
  import tmr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [tmr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cpu_on_internal_ring_oscillator,
  input wire logic i_internal_ring_oscillator,
  input wire logic i_first_capture_input,
  input wire logic i_shared_pin,
  output logic o_shared_pin,
  output logic o_shared_pin_oe
);
  import tmr_pkg::*;

  logic [2:0] ctrl_r;
  logic [1:0] prescaler_select_reg_r;
  logic [3:0] edge_sel_r;
  logic timer_output_enable_r, invert_on_first_match_r, invert_on_second_match_r;
  logic one_shot_mode_enable_r, os_pend_r, os_active_r, ff_r;
  logic [CNT_W-1:0] first_compare_reg_r, second_compare_reg_r, timer_count_value_r;
  logic [ST_W-1:0] status_r;
  logic [3:0] pcnt_r;
  logic ring_s1_r, ring_s2_r, ring_s3_r, mode_s1_r, ring_mode_r;
  logic wr, setup, mapped, ring_rise, base_tick, smp, tick, run_en, running;
  logic m1, m2, step, os_start, edge_clear;
  logic [1:0] evt;
  logic [3:0] pmask;
  logic [31:0] rdata;

  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  assign run_en = ctrl_r[CTRL_RUN];

  // ring oscillator and its select are foreign levels, hence synchronised
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ring_s1_r <= 1'b0;
      ring_s2_r <= 1'b0;
      ring_s3_r <= 1'b0;
      mode_s1_r <= 1'b0;
      ring_mode_r <= 1'b0;
    end else if (i_ce) begin
      ring_s1_r <= i_internal_ring_oscillator;
      ring_s2_r <= ring_s1_r;
      ring_s3_r <= ring_s2_r;
      mode_s1_r <= i_cpu_on_internal_ring_oscillator;
      ring_mode_r <= mode_s1_r;
    end
  end

  assign ring_rise = ring_s2_r && !ring_s3_r;
  assign base_tick = ring_mode_r ? ring_rise : 1'b1; // RL4
  assign smp = ring_mode_r ? ring_rise : 1'b1; // RL5

  // in ring mode, inputs beyond this point are only as good as the ring clock rate
  generate
    for (genvar g = 0; g < 2; g++) begin : g_edge
      tmr_edge_det u_edge (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(g == 0 ? i_first_capture_input : i_shared_pin),
        .i_smp(smp),
        .i_en(run_en && (g == 0 || !timer_output_enable_r)), // RL10
        .i_sel(edge_sel_r[2*g +: 2]),
        .o_evt(evt[g])
      );
    end
  endgenerate

  always_comb begin
    case (prescaler_select_reg_r)
      PS_DIV2: pmask = PS_MASK2;
      PS_DIV4: pmask = PS_MASK4;
      default: pmask = PS_MASK16;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcnt_r <= 4'h0;
    end else if (i_ce) begin
      if (!run_en) begin
        pcnt_r <= 4'h0;
      end else if (base_tick) begin
        pcnt_r <= pcnt_r + 4'h1;
      end
    end
  end

  // edge-as-clock leaves edge clearing unused; software must not mix them
  assign tick = run_en && ((prescaler_select_reg_r == PS_EXT) ? evt[0] :
                (base_tick && ((pcnt_r & pmask) == pmask))); // RL4
  assign edge_clear = ctrl_r[CTRL_CLR_EDGE] && evt[0] &&
                      prescaler_select_reg_r != PS_EXT && !one_shot_mode_enable_r; // RL7
  assign running = one_shot_mode_enable_r ? os_active_r : 1'b1;
  assign m1 = timer_count_value_r == first_compare_reg_r;
  assign m2 = timer_count_value_r == second_compare_reg_r;
  assign step = tick && running;
  assign os_start = run_en && one_shot_mode_enable_r && !os_active_r &&
                    (os_pend_r || (evt[0] && prescaler_select_reg_r != PS_EXT));

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_count_value_r <= '0;
    end else if (i_ce) begin
      if (!run_en || os_start || edge_clear) begin
        timer_count_value_r <= '0;
      end else if (step) begin
        if (m1 && ctrl_r[CTRL_CLR_MATCH]) begin
          timer_count_value_r <= '0;
        end else begin
          timer_count_value_r <= timer_count_value_r + 16'h0001;
        end
      end
    end
  end

  // an edge retrigger during an active pulse is ignored; a written trigger waits in os_pend_r until the pulse ends
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      os_active_r <= 1'b0;
      os_pend_r <= 1'b0;
    end else if (i_ce) begin
      if (!run_en || !one_shot_mode_enable_r) begin
        os_active_r <= 1'b0;
      end else if (os_start) begin
        os_active_r <= 1'b1;
      end else if (step && m1) begin
        os_active_r <= 1'b0;
      end
      if (wr && i_paddr == OFS_OUTCTL && i_pwdata[OC_OSPT]) begin
        os_pend_r <= 1'b1; // RL11
      end else if (os_start || !run_en) begin
        os_pend_r <= 1'b0; // RL1
      end
    end
  end

  // set/reset written on their own; the bits are never stored
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ff_r <= 1'b0;
    end else if (i_ce) begin
      if (wr && i_paddr == OFS_OUTCTL && i_pwdata[OC_FF_SET]) begin
        ff_r <= 1'b1; // RL2 RL3
      end else if (wr && i_paddr == OFS_OUTCTL && i_pwdata[OC_FF_RST]) begin
        ff_r <= 1'b0; // RL3
      end else if (step) begin
        ff_r <= ff_r ^ (invert_on_first_match_r && m1) ^ (invert_on_second_match_r && m2);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_shared_pin <= 1'b0;
      o_shared_pin_oe <= 1'b0;
    end else if (i_ce) begin
      o_shared_pin <= timer_output_enable_r && ff_r; // RL14
      o_shared_pin_oe <= timer_output_enable_r; // RL10 RL14
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= '0;
      prescaler_select_reg_r <= PS_DIV2;
      edge_sel_r <= {EDGE_NONE, EDGE_NONE};
      timer_output_enable_r <= 1'b0;
      invert_on_first_match_r <= 1'b0;
      invert_on_second_match_r <= 1'b0;
      one_shot_mode_enable_r <= 1'b0;
      first_compare_reg_r <= CMP_RESET;
      second_compare_reg_r <= CMP_RESET;
    end else if (i_ce && wr) begin
      case (i_paddr)
        OFS_CTRL: ctrl_r <= i_pwdata[2:0];
        OFS_PRESC: prescaler_select_reg_r <= i_pwdata[1:0]; // RL6
        OFS_EDGE: edge_sel_r <= i_pwdata[3:0];
        OFS_OUTCTL: begin
          timer_output_enable_r <= i_pwdata[OC_TOE];
          invert_on_first_match_r <= i_pwdata[OC_INV1];
          invert_on_second_match_r <= i_pwdata[OC_INV2]; // RL13
          one_shot_mode_enable_r <= i_pwdata[OC_OSPE];
        end
        OFS_CMP1: first_compare_reg_r <= i_pwdata[CNT_W-1:0];
        OFS_CMP2: second_compare_reg_r <= i_pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // hardware set wins over a same-cycle write-one clear
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_r <= '0;
    end else if (i_ce) begin
      status_r <= (status_r & ~((wr && i_paddr == OFS_STATUS) ? i_pwdata[ST_W-1:0] : 4'h0))
                  | {step && m2, step && m1, evt[1], evt[0]};
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (i_paddr)
      OFS_CTRL: rdata[2:0] = ctrl_r;
      OFS_PRESC: rdata[1:0] = prescaler_select_reg_r;
      OFS_EDGE: rdata[3:0] = edge_sel_r;
      OFS_OUTCTL: begin
        rdata[OC_TOE] = timer_output_enable_r;
        rdata[OC_INV1] = invert_on_first_match_r;
        rdata[OC_INV2] = invert_on_second_match_r;
        rdata[OC_OSPE] = one_shot_mode_enable_r;
        rdata[OC_FF_STATE] = ff_r;
      end
      OFS_CMP1: rdata[CNT_W-1:0] = first_compare_reg_r;
      OFS_CMP2: rdata[CNT_W-1:0] = second_compare_reg_r;
      OFS_COUNT: rdata[CNT_W-1:0] = timer_count_value_r;
      OFS_STATUS: rdata[ST_W-1:0] = status_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup && !i_pwrite) begin
        o_prdata <= rdata; // RL11 RL12
      end
    end
  end

  a_ring_count_clk: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (ring_mode_r && tick && prescaler_select_reg_r != PS_EXT) |-> ring_rise) // RL4
    else $error("count tick without ring oscillator edge");
  a_ring_sampling: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (ring_mode_r && smp) |-> ring_rise) // RL5
    else $error("input sampled off the ring oscillator");
  a_shared_pin_excl: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && timer_output_enable_r) ##1 timer_output_enable_r |-> !evt[1]) // RL10
    else $error("capture edge seen while pin drives output");
  a_trigger_reads_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && setup && !i_pwrite && i_paddr == OFS_OUTCTL) |=> !o_prdata[OC_OSPT]) // RL11
    else $error("one-shot trigger bit read back as one");
  a_setrst_read_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && setup && !i_pwrite && i_paddr == OFS_OUTCTL)
      |=> (o_prdata[OC_FF_SET] == 1'b0 && o_prdata[OC_FF_RST] == 1'b0)) // RL12
    else $error("flip-flop set or reset bit read back as one");
  a_pin_follows_ff: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && timer_output_enable_r) |=> (o_shared_pin_oe && o_shared_pin == $past(ff_r))) // RL14
    else $error("output pin not following flip-flop");
  a_pin_released: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && !timer_output_enable_r) |=> (!o_shared_pin_oe && !o_shared_pin)) // RL14
    else $error("output pin driven while output disabled");
  a_trigger_clears: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && os_start) |=> (os_active_r && !os_pend_r && timer_count_value_r == '0)) // RL11
    else $error("one-shot start did not clear trigger and counter");
endmodule // tmr_timer
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the timer block over APB
// Assumes: no wait states on APB, edge events a few cycles after a pin change
// Notes: clock enable tied high; pin levels come from the pin model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic i_core_clk, i_resetn, psel, penable, pwrite, cpu_ring, errv;
  logic first_pin, shared_in, ring, o_pready, o_pslverr, o_shared_pin, o_shared_pin_oe;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, o_prdata, rdv;
  logic [ADDR_W-1:0] ofs [8] = '{OFS_CTRL, OFS_PRESC, OFS_EDGE, OFS_OUTCTL, OFS_CMP1,
    OFS_CMP2, OFS_COUNT, OFS_STATUS};
  logic [31:0] rst [8] = '{32'h0, 32'h0, 32'hA, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0};
  int fails = 0;
  int total_checks = 0;
  tmr_timer i_tmr_timer (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_cpu_on_internal_ring_oscillator(cpu_ring), .i_internal_ring_oscillator(ring), .i_first_capture_input(first_pin),
    .i_shared_pin(shared_in), .o_shared_pin(o_shared_pin), .o_shared_pin_oe(o_shared_pin_oe));
  tmr_pins_model i_tmr_pins_model (.i_out(o_shared_pin), .i_oe(o_shared_pin_oe),
    .o_first(first_pin), .o_shared(shared_in), .o_ring(ring));
  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_core_clk);
    penable <= 1'b1;
    // pready is read at the rising edge itself, the edge that completes the access
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1, "apb answer missing");
      end_sim();
    end
    rdv = o_prdata;
    errv = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, m);
    chk({31'h0, errv}, 32'h0, m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task automatic poll(input logic [31:0] mask, input string m);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((rdv & mask) == 32'h0 && n < 30);
    chk(rdv & mask, mask, m);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cpu_ring = 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd_chk(ofs[k], rst[k], "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, errv}, 32'h1, "unmapped error");
    chk(rdv, 32'h0, "unmapped data");
    $display("test reset values done");
    apb(1'b1, OFS_EDGE, 32'h9);
    apb(1'b1, OFS_CTRL, 32'h1);
    poll(32'h1, "edge after reset with pin high");
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    idle(20);
    rd_chk(OFS_STATUS, 32'h0, "edge after re-enable");
    $display("test pin high edges done");
    apb(1'b1, OFS_EDGE, 32'hE);
    apb(1'b1, OFS_OUTCTL, 32'h1);
    idle(3);
    chk({30'h0, o_shared_pin_oe, o_shared_pin}, 32'h2, "enabled pin low");
    apb(1'b1, OFS_OUTCTL, 32'h9);
    idle(3);
    chk({30'h0, o_shared_pin_oe, o_shared_pin}, 32'h3, "pin follows ff set");
    rd_chk(OFS_OUTCTL, 32'h81, "set bit reads zero");
    apb(1'b1, OFS_OUTCTL, 32'h5);
    idle(3);
    chk({30'h0, o_shared_pin_oe, o_shared_pin}, 32'h2, "pin follows ff reset");
    rd_chk(OFS_OUTCTL, 32'h01, "reset bit reads zero");
    apb(1'b1, OFS_OUTCTL, 32'h21);
    apb(1'b1, OFS_OUTCTL, 32'h61);
    rd_chk(OFS_OUTCTL, 32'h21, "trigger bit reads zero");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdv & 32'h2, 32'h0, "no second edge while output");
    apb(1'b1, OFS_OUTCTL, 32'h0);
    idle(3);
    chk({31'h0, o_shared_pin_oe}, 32'h0, "pin released");
    @(posedge i_core_clk);
    i_tmr_pins_model.set_shared(1'b1);
    poll(32'h2, "second input edge when not output");
    $display("test output and shared pin done");
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMP1, 32'h7);
    apb(1'b1, OFS_CMP2, 32'h3);
    apb(1'b1, OFS_OUTCTL, 32'h13);
    apb(1'b1, OFS_STATUS, 32'hF);
    apb(1'b1, OFS_CTRL, 32'h3);
    poll(32'h8, "second match seen");
    apb(1'b0, OFS_COUNT, 32'h0);
    chk({31'h0, rdv <= 32'h7}, 32'h1, "count wraps at first compare");
    apb(1'b1, OFS_OUTCTL, 32'h03);
    apb(1'b1, OFS_CMP2, 32'h5);
    idle(2);
    apb(1'b1, OFS_OUTCTL, 32'h13);
    apb(1'b1, OFS_STATUS, 32'h8);
    poll(32'h8, "second match after width change");
    rd_chk(OFS_CMP2, 32'h5, "new second compare");
    $display("test match and width change done");
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_PRESC, 32'h0);
    @(posedge i_core_clk);
    cpu_ring <= 1'b1;
    idle(5);
    apb(1'b1, OFS_CTRL, 32'h1);
    idle(30);
    rd_chk(OFS_COUNT, 32'h0, "no count while ring still");
    i_tmr_pins_model.run_ring(1'b1);
    idle(60);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk({31'h0, rdv != 32'h0 && rdv < 32'hC}, 32'h1, "count from ring rate");
    $display("test ring oscillator clock done");
    end_sim();
  end
endmodule // tb
`default_nettype wire

// ==== sim/tmr_pins_model.sv ====
// Purpose: pin-side model of the capture inputs, the shared pin and the ring oscillator
// Assumes: the bench sets the outside shared pin level and starts the ring through the tasks below
// Notes: the ring oscillator stands still until the bench starts it
`timescale 1ns/1ps
`default_nettype none
module tmr_pins_model (
  input wire logic i_out,
  input wire logic i_oe,
  output logic o_first,
  output logic o_shared,
  output logic o_ring
);
  logic ext_shared;
  logic ring_run;
  // pulled up, so high straight after reset
  initial o_first = 1'b1;
  initial ext_shared = 1'b0;
  initial ring_run = 1'b0;
  // the timer owns the pin while enabled, else the outside level shows
  assign o_shared = i_oe ? i_out : ext_shared;
  // odd half period keeps it unrelated to the core clock
  initial begin
    o_ring = 1'b0;
    forever begin
      #37;
      if (ring_run) begin
        o_ring = ~o_ring;
      end
    end
  end
  // called right after a rising core edge, so the level changes like any stimulus
  task automatic set_shared(input logic v);
    ext_shared <= v;
  endtask
  task automatic run_ring(input logic v);
    ring_run = v;
  endtask
endmodule // tmr_pins_model
`default_nettype wire
